// file: inc/pmc_pkg.sv
/*
 Shared constants and types of the power monitor core.
 Assumes the converter and the serial block run on core_clk.
*/
package pmc_pkg;
  localparam int RES_W  = 12;
  localparam int PWR_W  = 24;
  localparam int NUM_CH = 3;
  // Channel codes
  localparam logic [1:0] CH_SENSE  = 2'h0;
  localparam logic [1:0] CH_SUPPLY = 2'h1;
  localparam logic [1:0] CH_AUX    = 2'h2;
  // Control register fields
  localparam int CTL_SNAP = 7;
  localparam int CTL_CH_HI = 6;
  localparam int CTL_CH_LO = 5;
  localparam int CTL_BUSY = 3;
  localparam int CTL_VSEL = 2;
  localparam int CTL_SHDN = 1;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // Register pointers
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_ALERT_EN = 8'h01;
  localparam logic [7:0] REG_RESULT   = 8'h02;
  localparam logic [7:0] REG_POWER    = 8'h08;
  localparam logic [7:0] REG_EXTREME  = 8'h0B;
  localparam logic [7:0] REG_THRESH   = 8'h17;
  localparam logic [7:0] REG_FAULT    = 8'h23;
  localparam logic [7:0] RESULT_CNT   = 8'h06;
  localparam logic [7:0] POWER_CNT    = 8'h03;
  localparam logic [7:0] BLOCK12_CNT  = 8'h0C;
  // Slave addressing
  localparam logic [6:0] ADDR_BASE = 7'h67;
  localparam logic [6:0] ARA_ADDR  = 7'h0C;
  localparam logic [6:0] ADDR_STEP = 7'h03;
  localparam logic [1:0] PIN_LOW   = 2'h0;
  localparam logic [1:0] PIN_HIGH  = 2'h1;
  localparam logic [1:0] PIN_OPEN  = 2'h2;
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // Reset values
  localparam logic [11:0] MIN_RST    = 12'hFFF;
  localparam logic [11:0] MAX_RST    = 12'h000;
  localparam logic [11:0] THR_LO_RST = 12'h000;
  localparam logic [11:0] THR_HI_RST = 12'hFFF;

  typedef enum logic [3:0] {
    BUS_IDLE = 4'h0, BUS_ADDR = 4'h1, BUS_ADDR_ACK = 4'h2,
    BUS_PTR = 4'h3, BUS_PTR_ACK = 4'h4, BUS_WDATA = 4'h5,
    BUS_WDATA_ACK = 4'h6, BUS_RDATA = 4'h7, BUS_RD_ACK = 4'h8
  } pmc_bus_state_t;

  typedef enum logic [0:0] {CV_IDLE = 1'b0, CV_WAIT = 1'b1} pmc_conv_state_t;

  typedef struct packed {
    logic       start;
    logic [1:0] chan;
    logic       supply_sel;
  } pmc_conv_req_t;

  typedef struct packed {
    logic              done;
    logic [RES_W-1:0]  data;
  } pmc_conv_res_t;
endpackage

// file: hw/pmc_sync.sv
/*
 Two flip-flop synchroniser for a vector of slow levels.
 Assumes each bit changes slowly against core_clk.
*/
`timescale 1ns/1ps
module pmc_sync import pmc_pkg::*; #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } pmc_sync_state_t;

  pmc_sync_state_t s_reg;
  pmc_sync_state_t s_next;

  if (W < 1) begin : g_chk
    $error("pmc_sync width must be at least one");
  end

  // Shift through two stages
  always_comb begin
    s_next        = s_reg;
    s_next.meta   = d;
    s_next.stable = s_reg.meta;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign q = s_reg.stable;
endmodule

// file: hw/pmc_extreme.sv
/*
 Running minimum and maximum of one converted quantity.
 Assumes en is a one-cycle pulse with data valid beside it.
*/
`timescale 1ns/1ps
module pmc_extreme import pmc_pkg::*; (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             en,
  input  wire logic [RES_W-1:0] data,
  output logic      [RES_W-1:0] min_val,
  output logic      [RES_W-1:0] max_val
);
  typedef struct packed {
    logic [RES_W-1:0] lo;
    logic [RES_W-1:0] hi;
  } pmc_ext_state_t;

  pmc_ext_state_t s_reg;
  pmc_ext_state_t s_next;

  always_comb begin
    s_next = s_reg;
    if (en && data < s_reg.lo) begin
      s_next.lo = data;
    end
    if (en && data > s_reg.hi) begin
      s_next.hi = data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg.lo <= MIN_RST;
      s_reg.hi <= MAX_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign min_val = s_reg.lo;
  assign max_val = s_reg.hi;

  min_track_a: assert property (@(posedge clk) disable iff (!rst_n)
    en |=> (s_reg.lo <= $past(data)) && (s_reg.hi >= $past(data)))
    else $error("extreme registers missed a result");
endmodule

// file: hw/pmc_core.sv
/*
 Digital core of the power monitor: serial slave, converter sequencer,
 result, power, extreme and threshold registers, open-drain alert.
 Assumes a converter on core_clk that takes a start pulse and returns
 one done pulse with data; pins and supply status are asynchronous.
*/
`timescale 1ns/1ps
module pmc_core import pmc_pkg::*; #(
  parameter bit INVERT_OUT = 1'b0
) (
  input  wire logic          core_clk,
  input  wire logic          rstn,
  input  wire logic          scl_i,
  input  wire logic          serial_data_in,
  output logic               serial_data_out_o,
  output logic               serial_data_out_oe,
  output logic               alert_n_o,
  output logic               alert_n_oe,
  input  wire logic [1:0]    addr_select_hi,
  input  wire logic [1:0]    addr_select_lo,
  input  wire logic          internal_low_supply_ok,
  output pmc_conv_req_t      conv_req,
  input  wire pmc_conv_res_t conv_res,
  output logic               conv_enable
);
  typedef struct packed {
    logic [1:0]             strap_cnt;
    logic [6:0]             dev_addr;
    logic                   scl_q;
    logic                   sda_q;
    pmc_bus_state_t         bus_st;
    logic [3:0]             bit_cnt;
    logic [7:0]             shreg;
    logic [7:0]             ptr;
    logic                   rw;
    logic                   ara;
    logic                   sdo_low;
    logic [7:0]             ctrl;
    logic [5:0]             alert_en;
    logic [5:0][RES_W-1:0]  thr;
    logic [2:0][RES_W-1:0]  res;
    logic [PWR_W-1:0]       pwr;
    logic                   pwr_upd;
    logic [5:0]             fault;
    logic                   alert;
    pmc_conv_state_t        cv_st;
    logic [1:0]             scan_ch;
    logic [1:0]             cur_ch;
    logic                   snap_halt;
    pmc_conv_req_t          req;
  } pmc_core_state_t;

  pmc_core_state_t       s_reg;
  pmc_core_state_t       s_next;
  logic                  rst_n;
  logic [6:0]            pins_s;
  logic                  scl_s;
  logic                  sda_s;
  logic                  uv_ok_s;
  logic [1:0]            hi_s;
  logic [1:0]            lo_s;
  logic [2:0]            ext_en;
  logic [2:0][RES_W-1:0] min_v;
  logic [2:0][RES_W-1:0] max_v;
  logic [7:0]            rd_byte;
  logic [7:0]            tx_byte;
  logic [PWR_W-1:0]      pwr_prod;
  logic                  run_ok;
  logic                  ctl_wr;

  function automatic logic [7:0] half_byte(input logic [RES_W-1:0] v, input logic low_half);
    half_byte = low_half ? {v[3:0], 4'h0} : v[11:4];
  endfunction

  function automatic logic [1:0] tri_code(input logic [1:0] c);
    tri_code = (c == PIN_LOW || c == PIN_HIGH) ? c : PIN_OPEN;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers
  pmc_sync #(.W(1)) u_rst_sync (
    .clk   (core_clk),
    .rst_n (rstn),
    .d     (1'b1),
    .q     (rst_n)
  );

  // Host pins sampled as plain levels
  pmc_sync #(.W(7)) u_pin_sync (
    .clk   (core_clk),
    .rst_n (rst_n),
    .d     ({scl_i, serial_data_in, internal_low_supply_ok, addr_select_hi, addr_select_lo}),
    .q     (pins_s)
  );

  assign {scl_s, sda_s, uv_ok_s, hi_s, lo_s} = pins_s;

  ////////////////////////////////////////////////////////////////////////////
  // Extreme trackers, one per channel
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ext
    assign ext_en[c] = s_reg.cv_st == CV_WAIT && conv_res.done && run_ok && s_reg.cur_ch == 2'(c);
    pmc_extreme u_ext (
      .clk     (core_clk),
      .rst_n   (rst_n),
      .en      (ext_en[c]),
      .data    (conv_res.data),
      .min_val (min_v[c]),
      .max_val (max_v[c])
    );
  end

  // Converter runs only when powered and awake
  assign run_ok   = !s_reg.ctrl[CTL_SHDN] && uv_ok_s;
  assign pwr_prod = s_reg.res[0] * s_reg.res[1];

  ////////////////////////////////////////////////////////////////////////////
  // Register read decode
  always_comb begin
    logic [7:0] off;
    off     = 8'h00;
    rd_byte = 8'h00;
    if (s_reg.ptr == REG_CTRL) begin
      rd_byte = s_reg.ctrl;
    end else if (s_reg.ptr == REG_ALERT_EN) begin
      rd_byte = {2'b00, s_reg.alert_en};
    end else if (s_reg.ptr >= REG_RESULT && s_reg.ptr < REG_RESULT + RESULT_CNT) begin
      off     = s_reg.ptr - REG_RESULT;
      rd_byte = half_byte(s_reg.res[off[2:1]], off[0]);
    end else if (s_reg.ptr >= REG_POWER && s_reg.ptr < REG_POWER + POWER_CNT) begin
      off     = s_reg.ptr - REG_POWER;
      rd_byte = (off[1:0] == 2'h0) ? s_reg.pwr[23:16] : (off[1:0] == 2'h1) ? s_reg.pwr[15:8] : s_reg.pwr[7:0];
    end else if (s_reg.ptr >= REG_EXTREME && s_reg.ptr < REG_EXTREME + BLOCK12_CNT) begin
      off     = s_reg.ptr - REG_EXTREME;
      rd_byte = half_byte(off[1] ? max_v[off[3:2]] : min_v[off[3:2]], off[0]);
    end else if (s_reg.ptr >= REG_THRESH && s_reg.ptr < REG_THRESH + BLOCK12_CNT) begin
      off     = s_reg.ptr - REG_THRESH;
      rd_byte = half_byte(s_reg.thr[off[3:1]], off[0]);
    end else if (s_reg.ptr == REG_FAULT) begin
      rd_byte = {2'b00, s_reg.fault};
    end
  end

  assign tx_byte = s_reg.ara ? {s_reg.dev_addr, 1'b0} : rd_byte;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic: strap capture, serial slave, sequencer
  always_comb begin
    logic       rise;
    logic       fall;
    logic       start_c;
    logic       stop_c;
    logic [7:0] off;
    logic [5:0] newf;
    logic [1:0] snap_ch;
    rise    = scl_s && !s_reg.scl_q;
    fall    = !scl_s && s_reg.scl_q;
    start_c = scl_s && s_reg.scl_q && s_reg.sda_q && !sda_s;
    stop_c  = scl_s && s_reg.scl_q && !s_reg.sda_q && sda_s;
    off     = 8'h00;
    newf    = 6'h00;
    snap_ch = (s_reg.ctrl[CTL_CH_HI:CTL_CH_LO] == 2'h3) ? CH_AUX : s_reg.ctrl[CTL_CH_HI:CTL_CH_LO];
    ctl_wr  = 1'b0;
    s_next  = s_reg;
    s_next.scl_q     = scl_s;
    s_next.sda_q     = sda_s;
    s_next.req.start = 1'b0;
    s_next.pwr_upd   = 1'b0;

    // Address straps caught after reset release
    if (s_reg.strap_cnt != STRAP_WAIT) begin
      s_next.strap_cnt = s_reg.strap_cnt + 2'h1;
      s_next.dev_addr  = ADDR_BASE + {5'h00, tri_code(hi_s)} * ADDR_STEP + {5'h00, tri_code(lo_s)};
    end

    if (start_c) begin
      s_next.bus_st  = BUS_ADDR;
      s_next.bit_cnt = 4'h0;
      s_next.sdo_low = 1'b0;
      s_next.ara     = 1'b0;
    end else if (stop_c) begin
      s_next.bus_st  = BUS_IDLE;
      s_next.sdo_low = 1'b0;
    end else begin
      case (s_reg.bus_st)
        BUS_ADDR, BUS_PTR, BUS_WDATA: begin
          if (rise) begin
            s_next.shreg   = {s_reg.shreg[6:0], sda_s};
            s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
          end
          if (fall && s_reg.bit_cnt == BYTE_BITS) begin
            s_next.bit_cnt = 4'h0;
            s_next.sdo_low = 1'b1;
            if (s_reg.bus_st == BUS_ADDR) begin
              // Answer only own or response address
              if (s_reg.shreg[7:1] == s_reg.dev_addr) begin
                s_next.rw     = s_reg.shreg[0];
                s_next.bus_st = BUS_ADDR_ACK;
              end else if (s_reg.shreg[7:1] == ARA_ADDR && s_reg.shreg[0] && s_reg.alert) begin
                s_next.rw     = 1'b1;
                s_next.ara    = 1'b1;
                s_next.bus_st = BUS_ADDR_ACK;
              end else begin
                s_next.sdo_low = 1'b0;
                s_next.bus_st  = BUS_IDLE;
              end
            end else if (s_reg.bus_st == BUS_PTR) begin
              s_next.ptr    = s_reg.shreg;
              s_next.bus_st = BUS_PTR_ACK;
            end else begin
              s_next.ptr    = s_reg.ptr + 8'h01;
              s_next.bus_st = BUS_WDATA_ACK;
              if (s_reg.ptr == REG_CTRL) begin
                ctl_wr = 1'b1;
                s_next.ctrl = {s_reg.shreg[7:4], s_reg.ctrl[CTL_BUSY], s_reg.shreg[2:0]};
                s_next.snap_halt = 1'b0;
              end else if (s_reg.ptr == REG_ALERT_EN) begin
                s_next.alert_en = s_reg.shreg[5:0];
              end else if (s_reg.ptr >= REG_THRESH && s_reg.ptr < REG_THRESH + BLOCK12_CNT) begin
                off = s_reg.ptr - REG_THRESH;
                if (off[0]) begin
                  s_next.thr[off[3:1]][3:0] = s_reg.shreg[7:4];
                end else begin
                  s_next.thr[off[3:1]][11:4] = s_reg.shreg;
                end
              end
            end
          end
        end
        BUS_ADDR_ACK: begin
          if (fall && s_reg.rw) begin
            s_next.shreg   = {tx_byte[6:0], 1'b0};
            s_next.sdo_low = !tx_byte[7];
            s_next.ptr     = s_reg.ara ? s_reg.ptr : s_reg.ptr + 8'h01;
            s_next.bus_st  = BUS_RDATA;
          end else if (fall) begin
            s_next.sdo_low = 1'b0;
            s_next.bus_st  = BUS_PTR;
          end
        end
        BUS_PTR_ACK, BUS_WDATA_ACK: begin
          if (fall) begin
            s_next.sdo_low = 1'b0;
            s_next.bus_st  = BUS_WDATA;
          end
        end
        BUS_RDATA: begin
          if (rise) begin
            s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
          end
          // Next bit set up for the host's rising edge
          if (fall && s_reg.bit_cnt == BYTE_BITS) begin
            s_next.bit_cnt = 4'h0;
            s_next.sdo_low = 1'b0;
            s_next.bus_st  = BUS_RD_ACK;
          end else if (fall) begin
            s_next.sdo_low = !s_reg.shreg[7];
            s_next.shreg   = {s_reg.shreg[6:0], 1'b0};
          end
        end
        BUS_RD_ACK: begin
          if (rise && s_reg.ara) begin
            // Alert released once its source is reported
            s_next.alert  = 1'b0;
            s_next.fault  = 6'h00;
            s_next.bus_st = BUS_IDLE;
          end else if (rise && sda_s) begin
            s_next.bus_st = BUS_IDLE;
          end else if (fall) begin
            s_next.shreg   = {tx_byte[6:0], 1'b0};
            s_next.sdo_low = !tx_byte[7];
            s_next.ptr     = s_reg.ptr + 8'h01;
            s_next.bus_st  = BUS_RDATA;
          end
        end
        default: begin
          s_next.bus_st = BUS_IDLE;
        end
      endcase
    end

    // Refresh power after a current or voltage result
    if (s_reg.pwr_upd) begin
      s_next.pwr = pwr_prod;
    end

    // Converter sequencer
    case (s_reg.cv_st)
      CV_IDLE: begin
        // Snapshot runs once, scan restarts whenever run_ok holds and no control write lands
        if (run_ok && s_reg.ctrl[CTL_SNAP] && !s_reg.snap_halt && !ctl_wr) begin
          s_next.req = '{start: 1'b1, chan: snap_ch, supply_sel: s_reg.ctrl[CTL_VSEL]};
          s_next.cur_ch = snap_ch;
          s_next.ctrl[CTL_BUSY] = 1'b1;
          s_next.cv_st = CV_WAIT;
        end else if (run_ok && !s_reg.ctrl[CTL_SNAP] && !ctl_wr) begin
          s_next.req = '{start: 1'b1, chan: s_reg.scan_ch, supply_sel: s_reg.ctrl[CTL_VSEL]};
          s_next.cur_ch = s_reg.scan_ch;
          s_next.cv_st = CV_WAIT;
        end
      end
      CV_WAIT: begin
        if (!run_ok) begin
          s_next.ctrl[CTL_BUSY] = 1'b0;
          s_next.cv_st = CV_IDLE;
        end else if (conv_res.done) begin
          s_next.res[s_reg.cur_ch] = conv_res.data;
          s_next.pwr_upd = s_reg.cur_ch != CH_AUX;
          newf[{s_reg.cur_ch, 1'b0}] = conv_res.data < s_reg.thr[{s_reg.cur_ch, 1'b0}];
          newf[{s_reg.cur_ch, 1'b1}] = conv_res.data > s_reg.thr[{s_reg.cur_ch, 1'b1}];
          newf = newf & s_reg.alert_en;
          // Set wins over a response clear
          s_next.fault = s_next.fault | newf;
          s_next.alert = s_next.alert | (|newf);
          s_next.cv_st = CV_IDLE;
          if (s_reg.ctrl[CTL_BUSY]) begin // Busy marks a snapshot, not a scan overtaken by a write
            // Busy clears; the converter halts unless a control write lands in the same cycle
            s_next.ctrl[CTL_BUSY] = 1'b0;
            s_next.snap_halt = !ctl_wr;
          end else begin
            s_next.scan_ch = (s_reg.scan_ch == CH_AUX) ? CH_SENSE : s_reg.scan_ch + 2'h1;
          end
        end
      end
      default: begin
        s_next.cv_st = CV_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg          <= '0;
      s_reg.dev_addr <= ADDR_BASE;
      s_reg.ctrl     <= CTRL_RST;
      s_reg.thr      <= {3{THR_HI_RST, THR_LO_RST}};
      s_reg.scan_ch  <= CH_SENSE;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs: open-drain pulls, converter request
  // Separate data output, optionally inverted
  assign serial_data_out_o  = 1'b0;
  assign serial_data_out_oe = INVERT_OUT ? !s_reg.sdo_low : s_reg.sdo_low;
  assign alert_n_o          = 1'b0;
  assign alert_n_oe         = s_reg.alert;
  assign conv_req           = s_reg.req;
  assign conv_enable        = run_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence snap_end_s;
    s_reg.cv_st == CV_WAIT && s_reg.ctrl[CTL_BUSY] && conv_res.done && run_ok && !ctl_wr;
  endsequence

  sequence result_in_s;
    s_reg.cv_st == CV_WAIT && conv_res.done && run_ok;
  endsequence

  snap_once_a: assert property (snap_end_s |=> !s_reg.req.start [*2])
    else $error("snapshot started a second conversion");
  busy_clear_a: assert property (snap_end_s |=> !s_reg.ctrl[CTL_BUSY] && s_reg.snap_halt)
    else $error("busy bit stayed set after snapshot");
  snap_busy_a: assert property (s_reg.req.start && s_reg.ctrl[CTL_SNAP] |-> s_reg.ctrl[CTL_BUSY])
    else $error("snapshot running without busy");
  scan_order_a: assert property (result_in_s and !s_reg.ctrl[CTL_BUSY] && s_reg.cur_ch == CH_SENSE
    |=> s_reg.scan_ch == CH_SUPPLY) else $error("scan order broken");
  result_store_a: assert property (result_in_s |=> s_reg.res[$past(s_reg.cur_ch)] == $past(conv_res.data))
    else $error("result not stored after conversion");
  power_mult_a: assert property (result_in_s and s_reg.cur_ch == CH_SENSE
    |=> ##1 s_reg.pwr == s_reg.res[0] * s_reg.res[1]) else $error("power not current times voltage");
  alert_mask_a: assert property ($rose(s_reg.alert) |-> ($past(s_reg.alert_en) & s_reg.fault) != 6'h00)
    else $error("alert raised by a masked fault");
  shutdown_stop_a: assert property (!run_ok |=> !s_reg.req.start)
    else $error("conversion started while stopped");
  addr_match_a: assert property (s_reg.bus_st == BUS_ADDR && s_next.bus_st == BUS_ADDR_ACK
    |-> s_reg.shreg[7:1] == s_reg.dev_addr || s_reg.shreg[7:1] == ARA_ADDR) else $error("foreign address acked");
  ack_drive_a: assert property (s_reg.bus_st == BUS_ADDR_ACK |-> serial_data_out_oe == !INVERT_OUT)
    else $error("address ack not driven");
endmodule

// file: testbench/pmc_host.sv
/* Bus host stand-in: clock and data input, pulled low or released.
   Assumes each call starts at a falling core_clk edge. */
`timescale 1ns/1ps
module pmc_host (
  input  wire logic oe,
  output logic      scl = 1'h1,
  output logic      sda = 1'h1
);
  // 800 ns clock; data set in low half, ab[0] midway through high half
  task automatic cond(input logic [1:0] ab);
    scl = 1'h0;
    #100 sda = ab[1];
    #300 scl = 1'h1;
    #200 sda = ab[0];
    #200;
  endtask
  // Nine bits, output line read as clock high ends
  task automatic x9(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      cond({2{d[i]}});
      q[i] = ~oe;
    end
  endtask
endmodule

// file: testbench/power_monitor_core_tb.sv
/* Bench: host and converter stand-ins around the core.
   Assumes plain data output and a 10 MHz core_clk. */
`timescale 1ns/1ps
module power_monitor_core_tb import pmc_pkg::*;;
  localparam logic [6:0] DEV = ADDR_BASE + ADDR_STEP + 7'h02;
  logic          core_clk = 1'h0, rstn = 1'h0, oe, alrt, en, scl, sda, sdo, ao, sel, sup = 1'h1;
  logic          oe2, sdo2, ao2, alrt2, en2;
  logic [8:0]    q, rq [13];
  logic [11:0]   cv [3] = '{12'h9A5, 12'h3C7, 12'h5E1};
  logic [1:0]    chs [$];
  int            miscompares = 0, n_compared = 0, cnt = 0, n;
  pmc_conv_req_t req, req2;
  pmc_conv_res_t res = '0;
  // Clock
  always #50 core_clk = ~core_clk;
  pmc_core uut (.core_clk, .rstn, .scl_i(scl), .serial_data_in(sda), .serial_data_out_o(sdo),
    .serial_data_out_oe(oe), .alert_n_o(ao), .alert_n_oe(alrt), .addr_select_hi(PIN_HIGH),
    .addr_select_lo(PIN_OPEN), .internal_low_supply_ok(sup), .conv_req(req), .conv_res(res), .conv_enable(en));
  // Inverting variant on the same pins, same converter
  pmc_core #(.INVERT_OUT(1'b1)) uut2 (.core_clk, .rstn, .scl_i(scl), .serial_data_in(sda),
    .serial_data_out_o(sdo2), .serial_data_out_oe(oe2), .alert_n_o(ao2), .alert_n_oe(alrt2),
    .addr_select_hi(PIN_HIGH), .addr_select_lo(PIN_OPEN), .internal_low_supply_ok(sup), .conv_req(req2),
    .conv_res(res), .conv_enable(en2));
  // Inverting output mirrors the plain one, all else equal
  always @(negedge core_clk) chk({oe2, alrt2, en2, req2, sdo2, ao2}, {~oe, alrt, en, req, 2'h0});
  pmc_host host (.oe(oe), .scl(scl), .sda(sda));
  // Converter: result 400 cycles after start, noise between
  always @(negedge core_clk) begin
    res = '{cnt == 1, cnt == 1 ? cv[chs[$]] : ~res.data};
    cnt = req.start ? 400 : cnt - int'(cnt > 0);
    sel = req.start ? req.supply_sel : sel;
    if (req.start) chs.push_back(req.chan);
  end
  task automatic chk(input logic [31:0] g, e);
    n_compared++;
    if (g !== e) $display("wrong value at %0t: %h vs %h", $time, g, e);
    miscompares += int'(g !== e);
  endtask
  // Transfer: write d at p, or read n bytes from p
  task automatic xf(input logic [7:0] p, d, input int n);
    host.cond(2'h2);
    host.x9({DEV, 2'h1}, q);
    chk(q[0], 0);
    host.x9({p, 1'h1}, q);
    if (n == 0) host.x9({d, 1'h1}, q);
    else host.cond(2'h2);
    if (n > 0) host.x9({DEV, 2'h3}, q);
    for (int i = 0; i < n; i++) host.x9({8'hFF, i == n - 1}, rq[i]);
    host.cond(2'h1);
  endtask
  task automatic t_scan();
    while (chs.size() < 7) @(negedge core_clk);
    for (int i = 0; i < 7; i++) chk(chs[i], i % 3);
    chk(sel, 0);
    xf(REG_RESULT, 8'h00, 13);
    for (int c = 0; c < 3; c++) chk({rq[2*c][8:1], rq[2*c+1][8:1]}, {cv[c], 4'h0});
    chk({rq[6][8:1], rq[7][8:1], rq[8][8:1]}, 24'(cv[0]) * cv[1]);
    chk({rq[9][8:1], rq[10][8:5], rq[11][8:1], rq[12][8:5]}, {cv[0], cv[0]});
  endtask
  task automatic t_snap();
    xf(REG_CTRL, 8'h02, 0);
    n = chs.size();
    #80000;
    chk(en, 0);
    cv[2] = 12'h123;
    xf(REG_CTRL, 8'hC4, 0);
    xf(REG_CTRL, 8'h00, 1);
    chk(rq[0][4], 1);
    #50000;
    xf(REG_CTRL, 8'h00, 8);
    chk({rq[0][4], rq[6][8:1], rq[7][8:1]}, {1'h0, cv[2], 4'h0});
    chk(chs.size() - n, 1);
    chk(sel, 1);
  endtask
  task automatic t_alrt();
    xf(REG_CTRL, 8'h00, 0);
    xf(REG_THRESH + 8'h02, 8'h00, 0);
    #130000;
    chk(alrt, 0);
    xf(REG_ALERT_EN, 8'h02, 0);
    #130000;
    chk(alrt, 1);
    host.cond(2'h2);
    host.x9({~DEV, 2'h1}, q);
    host.cond(2'h1);
    chk(q[0], 1);
    chk({sdo, ao}, 0);
    xf(REG_ALERT_EN, 8'h00, 0);
    host.cond(2'h2);
    host.x9({ARA_ADDR, 2'h3}, q);
    chk(q[0], 0);
    host.x9({8'hFF, 1'h1}, q);
    host.cond(2'h1);
    chk(q[8:1], {DEV, 1'h0});
    chk(alrt, 0);
  endtask
  task automatic t_supply();
    sup = 1'h0;
    #1000;
    chk(en, 0);
    n = chs.size();
    #50000;
    chk(chs.size() - n, 0);
    sup = 1'h1;
    #50000;
    chk(chs.size() > n, 1);
  endtask
  task automatic finish_test();
    if (miscompares == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Reset two cycles, then the scenarios
  initial begin
    #200 rstn = 1'h1;
    #800;
    t_scan();
    t_snap();
    t_alrt();
    t_supply();
    finish_test();
  end
  // Watchdog well past the expected run
  initial begin
    #4000000 miscompares++;
    finish_test();
  end
endmodule
